// File: hw/tap_chain.sv
// Purpose: instruction register, data chains and boundary cells of a test port
// Assumes: test-port pins and pads are asynchronous to core_clk, tck far slower
// Notes: tap state tracker included only so that chain actions have a state
`timescale 1ns/1ps
module tap_chain (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic rst_pin_n,
  input wire logic [tap_chain_pkg::NUM_PINS-1:0] pad_in,
  output logic [tap_chain_pkg::NUM_PINS-1:0] pad_out,
  output logic [tap_chain_pkg::NUM_PINS-1:0] pad_oe,
  input wire logic [tap_chain_pkg::NUM_PINS-1:0] core_out,
  input wire logic [tap_chain_pkg::NUM_PINS-1:0] core_oe,
  output logic [tap_chain_pkg::NUM_PINS-1:0] core_in,
  input wire logic [tap_chain_pkg::DBG_W-1:0] dbg_rdata,
  output tap_chain_pkg::dbg_req_s dbg_req,
  output logic dbg_write
);
  import tap_chain_pkg::*;

  function automatic chain_sel_e decode_ir(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST, OP_INTEST, OP_SAMPLE: decode_ir = CH_BOUNDARY;
      OP_ABORT: decode_ir = CH_ABORT;
      OP_DP_ACCESS: decode_ir = CH_DP;
      OP_AP_ACCESS: decode_ir = CH_AP;
      OP_IDCODE: decode_ir = CH_IDCODE;
      default: decode_ir = CH_BYPASS;
    endcase
  endfunction

  function automatic tap_state_e tap_next(input tap_state_e s, input logic m);
    case (s)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UPD_DR : PAU_DR;
      PAU_DR: tap_next = m ? EX2_DR : PAU_DR;
      EX2_DR: tap_next = m ? UPD_DR : SH_DR;
      UPD_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UPD_IR : PAU_IR;
      PAU_IR: tap_next = m ? EX2_IR : PAU_IR;
      EX2_IR: tap_next = m ? UPD_IR : SH_IR;
      UPD_IR: tap_next = m ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction

  function automatic logic in_shift(input tap_state_e s);
    in_shift = s == SH_IR || s == SH_DR;
  endfunction

  // three-stage sampling; a bit changes once stages two and three agree
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic [SYN_W-1:0] syn3_q;
  logic [SYN_W-1:0] filt_q;
  logic [SYN_W-1:0] filt_d;
  logic tck_prev_q;
  logic tck_rise;
  logic tck_fall;
  logic trst_act;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syn1_q <= SYN_RESET;
      syn2_q <= SYN_RESET;
      syn3_q <= SYN_RESET;
    end else begin
      syn1_q <= {trst_n, tck, tms, tdi, rst_pin_n, pad_in};
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
    end
  end

  always_comb begin
    filt_d = (syn2_q & ~(syn2_q ^ syn3_q)) | (filt_q & (syn2_q ^ syn3_q));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_q <= SYN_RESET;
      tck_prev_q <= SYN_RESET[SYN_TCK]; // idle level, else reset fakes a tck fall
    end else begin
      filt_q <= filt_d;
      tck_prev_q <= filt_q[SYN_TCK];
    end
  end

  assign tck_rise = filt_q[SYN_TCK] & ~tck_prev_q;
  assign tck_fall = ~filt_q[SYN_TCK] & tck_prev_q;
  assign trst_act = ~filt_q[SYN_TRST];

  // controller state; rst or the test reset pin clears the port, never the reset pin
  tap_state_e state_q;

  always_ff @(posedge core_clk) begin
    if (rst || trst_act) begin
      state_q <= TLR;
    end else if (tck_rise) begin
      state_q <= tap_next(state_q, filt_q[SYN_TMS]);
    end
  end

  // instruction chain and holding register
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;
  chain_sel_e sel;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise && state_q == CAP_IR) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise && state_q == SH_IR) begin
      ir_sh_q <= {filt_q[SYN_TDI], ir_sh_q[IR_W-1:1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || trst_act || state_q == TLR) begin
      ir_q <= IR_RESET;
    end else if (tck_fall && state_q == UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  assign sel = decode_ir(ir_q);

  // data chains; all reachable only through the serial port
  logic [BSR_LEN-1:0] bsr_sh_q;
  logic [BSR_LEN-1:0] bsr_hold_q;
  logic [BSR_LEN-1:0] bsr_cap;
  logic [ID_W-1:0] id_sh_q;
  logic byp_q;
  logic [DBG_W-1:0] dbg_sh_q;
  logic dr_cap;
  logic dr_shift;
  logic upd_dr;

  assign dr_cap = tck_rise && state_q == CAP_DR;
  assign dr_shift = tck_rise && state_q == SH_DR;
  assign upd_dr = tck_fall && state_q == UPD_DR;

  // each pin gives input, output, enable; the reset pin adds input only
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_cell
      assign bsr_cap[3*gi+CELL_IN] = filt_q[gi];
      assign bsr_cap[3*gi+CELL_OUT] = pad_out[gi];
      assign bsr_cap[3*gi+CELL_OE] = pad_oe[gi];
    end
  endgenerate
  assign bsr_cap[CELL_RST] = filt_q[SYN_RSTPIN];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bsr_sh_q <= '0;
    end else if (sel == CH_BOUNDARY && dr_cap) begin
      bsr_sh_q <= bsr_cap;
    end else if (sel == CH_BOUNDARY && dr_shift) begin
      bsr_sh_q <= {filt_q[SYN_TDI], bsr_sh_q[BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bsr_hold_q <= '0;
    end else if (sel == CH_BOUNDARY && upd_dr) begin
      bsr_hold_q <= bsr_sh_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      id_sh_q <= ID_VALUE;
    end else if (sel == CH_IDCODE && dr_cap) begin
      id_sh_q <= ID_VALUE;
    end else if (sel == CH_IDCODE && dr_shift) begin
      id_sh_q <= {filt_q[SYN_TDI], id_sh_q[ID_W-1:1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      byp_q <= 1'h0;
    end else if (sel == CH_BYPASS && dr_cap) begin
      byp_q <= 1'h0;
    end else if (sel == CH_BYPASS && dr_shift) begin
      byp_q <= filt_q[SYN_TDI];
    end
  end

  // one chain serves all three debug codes; the code tells the far side which
  logic dbg_sel;
  assign dbg_sel = sel == CH_ABORT || sel == CH_DP || sel == CH_AP;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dbg_sh_q <= '0;
    end else if (dbg_sel && dr_cap) begin
      dbg_sh_q <= dbg_rdata;
    end else if (dbg_sel && dr_shift) begin
      dbg_sh_q <= {filt_q[SYN_TDI], dbg_sh_q[DBG_W-1:1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dbg_write <= 1'h0;
    end else begin
      dbg_write <= dbg_sel && upd_dr;
    end
  end

  // port and data move on one edge, so the far side never sees half a request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dbg_req <= '{port: DBG_NONE, data: '0};
    end else begin
      if (dbg_sel && upd_dr) begin
        dbg_req.data <= dbg_sh_q;
        case (sel)
          CH_ABORT: dbg_req.port <= DBG_ABORT;
          CH_DP: dbg_req.port <= DBG_DP;
          CH_AP: dbg_req.port <= DBG_AP;
          default: dbg_req.port <= DBG_NONE;
        endcase
      end
    end
  end

  // serial output, moved on the falling edge so the host samples it stable
  logic dr_bit;

  always_comb begin
    case (sel)
      CH_BOUNDARY: dr_bit = bsr_sh_q[0];
      CH_IDCODE: dr_bit = id_sh_q[0];
      CH_ABORT, CH_DP, CH_AP: dr_bit = dbg_sh_q[0];
      default: dr_bit = byp_q;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tdo <= 1'h0;
    end else if (tck_fall && !trst_act) begin
      tdo <= state_q == SH_IR ? ir_sh_q[0] : dr_bit;
    end
  end

  // test reset only releases the pin; the data bit is left as it was
  always_ff @(posedge core_clk) begin
    if (rst || trst_act) begin
      tdo_oe_n <= 1'h1;
    end else if (tck_fall) begin
      tdo_oe_n <= !in_shift(state_q);
    end
  end

  // pad and core muxes; held cells replace live values only under the tests
  logic ext_mode;
  logic int_mode;

  assign ext_mode = ir_q == OP_EXTEST;
  assign int_mode = ir_q == OP_INTEST;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pad
      always_ff @(posedge core_clk) begin
        if (rst) begin
          pad_out[gp] <= 1'h0;
        end else begin
          pad_out[gp] <= ext_mode ? bsr_hold_q[3*gp+CELL_OUT] : core_out[gp];
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          pad_oe[gp] <= 1'h0;
        end else begin
          pad_oe[gp] <= ext_mode ? bsr_hold_q[3*gp+CELL_OE] : core_oe[gp];
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          core_in[gp] <= 1'h0;
        end else begin
          core_in[gp] <= int_mode ? bsr_hold_q[3*gp+CELL_IN] : filt_q[gp];
        end
      end
    end
  endgenerate
  // the reset cell's held bit feeds nothing, so internal reset is never forced
endmodule // tap_chain

// File: hw/tap_chain_pkg.sv
// Purpose: shared constants, types and codes for the test-port scan block
// Assumes: one 20 MHz core clock samples every test-port pin
// Notes: chain bit 0 is the cell nearest the serial output
// Behaviour
// - four-bit instruction shift chain backed by a parallel holding register.
// - shifted instruction bits act only after the update step copies them.
// - codes 0000, 0001, 0010 select external, internal, sample tests on boundary chain.
// - codes 1000, 1010, 1011 select abort, debug-port and access-port chains.
// - code 1110 selects identification, 1111 selects the one-stage bypass.
// - unlisted codes act exactly like bypass.
// - external test drives pads from held output and enable cells.
// - internal test drives core inputs from held input cells.
// - reset pin cell only observes, never drives the internal reset.
// - boundary capture of every pad input, output, enable in Capture-DR.
// - Shift-DR shifts captured bits out while new bits shift in.
// - Update-DR copies boundary chain into holding cells used by tests.
// - abort code selects a 35-bit chain reaching debug-port abort logic.
// - debug-port access code selects a 35-bit register access chain.
// - access-port access code selects a 35-bit component access chain.
// - holding register forced to identification on reset, trst, Test-Logic-Reset.
// - 32-bit identification chain captures fixed value with bit 0 set.
// - bypass chain captures 0 to tell it from identification.
// - three cells per pin: input, output, enable; reset pin one input cell.
// - chains reachable only serially, never through a processor bus.
// - power-on reset clears the port; the reset pin leaves it alone.
package tap_chain_pkg;
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int DBG_W = 35;
  localparam int NUM_PINS = 8;
  localparam int BSR_LEN = 3 * NUM_PINS + 1;
  // cell offsets inside one pin's group of three
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int CELL_RST = 3 * NUM_PINS;
  // sampled input vector layout: pads first, then port pins
  localparam int SYN_RSTPIN = NUM_PINS;
  localparam int SYN_TDI = NUM_PINS + 1;
  localparam int SYN_TMS = NUM_PINS + 2;
  localparam int SYN_TCK = NUM_PINS + 3;
  localparam int SYN_TRST = NUM_PINS + 4;
  localparam int SYN_W = NUM_PINS + 5;
  localparam logic [SYN_W-1:0] SYN_RESET = {1'h1, 1'h0, 1'h1, 1'h1, 1'h1, {NUM_PINS{1'h0}}};
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] OP_INTEST = 4'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] OP_ABORT = 4'h8;
  localparam logic [IR_W-1:0] OP_DP_ACCESS = 4'hA;
  localparam logic [IR_W-1:0] OP_AP_ACCESS = 4'hB;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'hE;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
  // arbitrary neutral identity value; bit 0 must stay 1
  localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5671;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_e;

  typedef enum logic [2:0] {
    CH_BOUNDARY, CH_ABORT, CH_DP, CH_AP, CH_IDCODE, CH_BYPASS
  } chain_sel_e;

  typedef enum logic [1:0] {
    DBG_ABORT, DBG_DP, DBG_AP, DBG_NONE
  } dbg_port_e;

  typedef struct packed {
    dbg_port_e port;
    logic [DBG_W-1:0] data;
  } dbg_req_s;
endpackage

// File: bench/tap_chain_chk.sv
// Purpose: timing checks on the test-port scan block outputs
// Assumes: tck idles low and each phase spans four core clocks
// Notes: sees only the block's ports; pin tck edges act five core clocks later
`timescale 1ns/1ps
module tap_chain_chk
  import tap_chain_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [NUM_PINS-1:0] core_oe,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire dbg_req_s dbg_req,
  input wire logic dbg_write
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_oe_after_reset: assert property ($past(rst) |-> tdo_oe_n)
    else $error("tdo driven right after reset");
  a_req_after_reset: assert property ($past(rst) |-> dbg_req.port == DBG_NONE)
    else $error("debug request not idle after reset");
  a_write_one_cycle: assert property (dbg_write |=> !dbg_write)
    else $error("debug write longer than one cycle");
  a_write_on_fall: assert property (dbg_write |-> $past(tck, 6) && !$past(tck, 5))
    else $error("debug write not five clocks after a tck fall");
  a_tdo_on_fall: assert property ($changed(tdo) |-> $past(tck, 6) && !$past(tck, 5))
    else $error("tdo moved other than after a tck fall");
  a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> $past(tck, 6) && !$past(tck, 5))
    else $error("tdo enable moved other than after a tck fall");
  a_req_needs_write: assert property ($changed(dbg_req) |-> dbg_write)
    else $error("debug request changed without write");
  a_pad_oe_cause: assert property ($changed(pad_oe) |-> $past(rst, 2) ||
    ($past(core_oe) != $past(core_oe, 2)) || ($past(tck, 7) && !$past(tck, 6)))
    else $error("pad enable changed without cause");
  c_write: cover property (dbg_write);
  c_drive: cover property ($fell(tdo_oe_n));
  c_pad: cover property ($changed(pad_oe));
endmodule // tap_chain_chk
bind tap_chain tap_chain_chk tap_chain_chk_inst (.core_clk(core_clk), .rst(rst), .tck(tck),
  .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_oe(core_oe), .pad_oe(pad_oe), .dbg_req(dbg_req),
  .dbg_write(dbg_write));

// File: bench/tap_probe.sv
// Purpose: behavioural test host driving the serial test pins
// Assumes: 400 ns tck period, tck stands low between scans
// Notes: tdo read just before tck falls, where it is surely settled
`timescale 1ns/1ps
module tap_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h1;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #200 tck = 1'h1;
    #150 q = tdo;
    #50 tck = 1'h0;
  endtask
  task automatic to_reset();
    logic q;
    repeat (5) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
  task automatic pulse_trst();
    logic q;
    trst_n = 1'h0;
    #400 trst_n = 1'h1;
    #400 step(1'h0, 1'h0, q);
  endtask
  // from idle: scan n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
    output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'h1, 1'h0, q);
    if (ir) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
endmodule // tap_probe

// File: bench/tap_chain_bench.sv
// Purpose: self-checking bench for the test-port scan block
// Assumes: host model drives the serial pins
// Notes: expected values come from the opcode and layout constants
`timescale 1ns/1ps
module tap_chain_bench;
  import tap_chain_pkg::*;
  logic core_clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe_n, rst_pin_n, dbg_write;
  logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
  logic [DBG_W-1:0] dbg_rdata;
  dbg_req_s dbg_req;
  logic [63:0] got;
  int n_mismatch = 0;
  int checks = 0;
  tap_chain tap_chain_inst (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .rst_pin_n(rst_pin_n), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .dbg_rdata(dbg_rdata), .dbg_req(dbg_req), .dbg_write(dbg_write));
  tap_probe tap_probe_inst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_id();
    tap_probe_inst.scan(1'h0, ID_W, 64'h0, got);
    check(got[ID_W-1:0], ID_VALUE);
    check(tdo_oe_n, 1'h1);
    tap_probe_inst.scan(1'h1, IR_W, 64'(OP_BYPASS), got);
    check(got[1:0], 2'h1);
    tap_probe_inst.scan(1'h0, 2, 64'h3, got);
    check(got[1:0], 2'h2);
    tap_probe_inst.pulse_trst();
    tap_probe_inst.scan(1'h0, ID_W, 64'h0, got);
    check(got[ID_W-1:0], ID_VALUE);
    $display("test id and bypass done");
  endtask
  task automatic t_reserved();
    logic [IR_W-1:0] codes [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD};
    foreach (codes[k]) begin
      tap_probe_inst.scan(1'h1, IR_W, 64'(codes[k]), got);
      tap_probe_inst.scan(1'h0, 2, 64'h3, got);
      check(got[1:0], 2'h2);
    end
    $display("test reserved codes done");
  endtask
  task automatic t_boundary();
    logic [BSR_LEN-1:0] pre = 25'h1B4C3A5;
    logic [BSR_LEN-1:0] exp;
    logic [NUM_PINS-1:0] eo, ee, ei;
    for (int i = 0; i < NUM_PINS; i++) begin
      exp[3*i +: 3] = {core_oe[i], core_out[i], pad_in[i]};
      ei[i] = pre[3*i+CELL_IN];
      eo[i] = pre[3*i+CELL_OUT];
      ee[i] = pre[3*i+CELL_OE];
    end
    exp[CELL_RST] = rst_pin_n;
    tap_probe_inst.scan(1'h1, IR_W, 64'(OP_SAMPLE), got);
    tap_probe_inst.scan(1'h0, BSR_LEN, 64'(pre), got);
    check(got[BSR_LEN-1:0], exp);
    tap_probe_inst.scan(1'h1, IR_W, 64'(OP_EXTEST), got);
    check({pad_oe, pad_out}, {ee, eo});
    tap_probe_inst.scan(1'h1, IR_W, 64'(OP_INTEST), got);
    check(core_in, ei);
    rst_pin_n = 1'h0;
    tap_probe_inst.scan(1'h0, BSR_LEN, 64'(pre), got);
    check(got[CELL_RST], 1'h0);
    check(core_in, ei);
    rst_pin_n = 1'h1;
    $display("test boundary done");
  endtask
  task automatic t_debug();
    logic [IR_W-1:0] op [3] = '{OP_ABORT, OP_DP_ACCESS, OP_AP_ACCESS};
    dbg_port_e pe [3] = '{DBG_ABORT, DBG_DP, DBG_AP};
    logic [DBG_W-1:0] wr;
    foreach (op[k]) begin
      dbg_rdata = {3'(k), 32'h89AB_CDEF};
      wr = {32'h1357_9BDF, 3'(k + 4)};
      tap_probe_inst.scan(1'h1, IR_W, 64'(op[k]), got);
      tap_probe_inst.scan(1'h0, DBG_W, 64'(wr), got);
      check(got[DBG_W-1:0], dbg_rdata);
      check(dbg_req, {pe[k], wr});
    end
    $display("test debug chains done");
  endtask
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'h1;
    rst_pin_n = 1'h1;
    pad_in = 8'hA5;
    core_out = 8'h3C;
    core_oe = 8'hF0;
    dbg_rdata = '0;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'h0;
    repeat (5) @(posedge core_clk);
    #1 tap_probe_inst.to_reset();
    t_id();
    t_reserved();
    t_boundary();
    t_debug();
    results();
  end
  // scans above need about 191 us
  initial begin
    #2_000_000;
    n_mismatch++;
    results();
  end
endmodule // tap_chain_bench
